// ==== spi_expander_pkg.sv ====
// Purpose: Shared constants and carriers for the SPI port expander
// Assumes: Single 20 MHz clock, synchronous active-high reset
// Notes: Overview list below
// Overview of operation
// - Output expander shifts MOSI on SCK while its select is low, drives eight outputs.
// - Reset clears output shift register and latch; all outputs go low.
// - One select captures eight inputs, another shifts them out on MISO with SCK.
// - MISO driven only while input shift select is active, otherwise released.
// - Three-bit code decodes to exactly one active-low select of eight.
package spi_expander_pkg;
    localparam int width = 8;
    localparam logic [2:0] code_input_capture = 3'h3;
    localparam logic [2:0] code_input_shift = 3'h4;
    localparam logic [2:0] code_output_expander = 3'h5;
    localparam logic [7:0] outputs_reset = 8'h00;
    localparam logic [7:0] selects_idle = 8'hff;

    // Synchronised SPI pin levels
    typedef struct packed {
        logic sck;
        logic mosi;
        logic [2:0] code;
    } spi_pins_type;
endpackage : spi_expander_pkg

// ==== spi_sync.sv ====
// Purpose: Two-flop synchroniser for a group of pin inputs
// Assumes: Inputs asynchronous to clock
// Notes: First stage is read only by the second
`timescale 1ns/1ns
module spi_sync #(
    parameter int bits = 5
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [bits-1:0] async_in,
    output logic [bits-1:0] sync_out
);
    logic [bits-1:0] stage1;

    // Two stages against metastability
    always_ff @(posedge clock) begin
        if (rst) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : spi_sync

// ==== spi_port_expander.sv ====
// Purpose: SPI port expander: select decoder, output and input shift registers
// Assumes: SCK idle low, data sampled on rising SCK; SCK much slower than clock
// Notes: Pins are oversampled; rst stands in for the board reset
`timescale 1ns/1ns
module spi_port_expander
    import spi_expander_pkg::*;
#(
    parameter int n = width
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic sck,
    input wire logic mosi,
    input wire logic [2:0] select_code_pins,
    input wire logic [n-1:0] expanded_inputs,
    output logic [7:0] selects_n,
    output logic [n-1:0] expanded_outputs,
    output logic miso_out,
    output logic miso_oe
);
    spi_pins_type pins;
    logic [n-1:0] inputs_sync;
    logic sck_prev;
    logic sck_rise;
    logic [7:0] next_selects_n;
    logic [n-1:0] out_shift;
    logic [n-1:0] in_shift;
    logic out_sel_prev;
    logic cap_sel_prev;
    logic capture_edge;
    logic [3:0] out_bits;

    // Pin synchronisers, SPI group and parallel inputs
    spi_sync #(.bits(5)) sync_spi (
        .clock(clock),
        .rst(rst),
        .async_in({sck, mosi, select_code_pins}),
        .sync_out(pins)
    );
    spi_sync #(.bits(n)) sync_in (
        .clock(clock),
        .rst(rst),
        .async_in(expanded_inputs),
        .sync_out(inputs_sync)
    );

    // One-hot active-low decode
    always_comb begin
        next_selects_n = selects_idle;
        next_selects_n[pins.code] = 1'b0;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            selects_n <= selects_idle;
        end else begin
            selects_n <= next_selects_n;
        end
    end

    // SCK edge detect on synchronised level
    always_ff @(posedge clock) begin
        if (rst) begin
            sck_prev <= 1'b0;
        end else begin
            sck_prev <= pins.sck;
        end
    end
    assign sck_rise = pins.sck & ~sck_prev;

    // Output shift register, MSB first; relies on code set before SCK
    always_ff @(posedge clock) begin
        if (rst) begin
            out_shift <= outputs_reset;
        end else if (sck_rise && !selects_n[code_output_expander]) begin
            out_shift <= {out_shift[n-2:0], pins.mosi};
        end
    end

    // Latch on select release so outputs never show partial data
    always_ff @(posedge clock) begin
        if (rst) begin
            out_sel_prev <= 1'b1;
            expanded_outputs <= outputs_reset;
        end else begin
            out_sel_prev <= selects_n[code_output_expander];
            if (selects_n[code_output_expander] && !out_sel_prev) begin
                expanded_outputs <= out_shift;
            end
        end
    end

    // Falling edge of the capture select, seen on the registered decode
    assign capture_edge = !selects_n[code_input_capture] && cap_sel_prev;

    // Input register: capture on capture select falling, shift on SCK
    always_ff @(posedge clock) begin
        if (rst) begin
            cap_sel_prev <= 1'b1;
            in_shift <= '0;
        end else begin
            cap_sel_prev <= selects_n[code_input_capture];
            if (capture_edge) begin
                in_shift <= inputs_sync;
            end else if (sck_rise && !selects_n[code_input_shift]) begin
                in_shift <= {in_shift[n-2:0], 1'b0};
            end
        end
    end

    // Tri-state buffer on MISO, shared with other slaves
    always_ff @(posedge clock) begin
        if (rst) begin
            miso_out <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            miso_out <= in_shift[n-1];
            miso_oe <= ~selects_n[code_input_shift];
        end
    end

    // Bits clocked into the output register since its select went low.
    // Only the cover below reads it; it saturates so long bursts cannot wrap.
    // Four bits suit the byte-wide register; a wider n needs a wider count.
    always_ff @(posedge clock) begin
        if (rst) begin
            out_bits <= '0;
        end else if (selects_n[code_output_expander]) begin
            out_bits <= '0;
        end else if (sck_rise && out_bits != 4'hf) begin
            out_bits <= out_bits + 4'h1;
        end
    end

    // Assertions. All run on clock; all but the two reset checks are held off while rst is high.
    // The decode register still shows the idle pattern in the first cycle
    // after reset, so the one-hot check skips that single cycle.

    // Decode: exactly one select low once reset has flushed
    AST_ONE_HOT: assert property (@(posedge clock) disable iff (rst)
        !$past(rst) |-> $onehot(~selects_n))
        else $error("select decode not one-hot");

    // Decode: the low select is the one the synchronised code names
    AST_DECODE: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> selects_n == ~(8'h01 << $past(pins.code)))
        else $error("decode does not follow code");

    // Reset leaves every select idle and the shared line released
    AST_RESET_PINS: assert property (@(posedge clock)
        rst |=> !miso_oe && selects_n == selects_idle)
        else $error("reset left a select or MISO active");

    // MISO buffer follows the shift select one cycle later
    AST_OE: assert property (@(posedge clock) disable iff (rst)
        !selects_n[code_input_shift] |=> miso_oe)
        else $error("MISO not driven while shift selected");

    // Other slaves own the line whenever the shift select is idle
    AST_RELEASE: assert property (@(posedge clock) disable iff (rst)
        selects_n[code_input_shift] |=> !miso_oe)
        else $error("MISO driven while not selected");

    // While driven, MISO carries the tail of the input register
    AST_MISO_TAIL: assert property (@(posedge clock) disable iff (rst)
        !selects_n[code_input_shift] |=> miso_out == $past(in_shift[n-1]))
        else $error("MISO does not show register tail");

    // Outputs frozen for the whole transfer, so no partial byte leaks
    AST_LATCH_HOLD: assert property (@(posedge clock) disable iff (rst)
        !selects_n[code_output_expander] |=> $stable(expanded_outputs))
        else $error("outputs changed mid transfer");

    // Outputs move only on the release of the output select
    AST_LATCH_ONLY_RELEASE: assert property (@(posedge clock) disable iff (rst)
        !$rose(selects_n[code_output_expander]) |=> $stable(expanded_outputs))
        else $error("outputs changed without select release");

    // On release the latch takes the shift register as it stood
    AST_LATCH_COPY: assert property (@(posedge clock) disable iff (rst)
        $rose(selects_n[code_output_expander]) |=> expanded_outputs == $past(out_shift))
        else $error("latch did not copy shift register");

    // Each SCK rise under the output select takes one MOSI bit
    AST_SHIFT: assert property (@(posedge clock) disable iff (rst)
        sck_rise && !selects_n[code_output_expander] |=> out_shift[0] == $past(pins.mosi))
        else $error("MOSI bit not shifted in");

    // SCK meant for another target must not disturb the output register
    AST_OUT_STILL: assert property (@(posedge clock) disable iff (rst)
        !(sck_rise && !selects_n[code_output_expander]) |=> $stable(out_shift))
        else $error("output register moved without its select");

    // Reset clears both the shift stage and the visible outputs
    AST_RESET: assert property (@(posedge clock)
        rst |=> expanded_outputs == outputs_reset && out_shift == outputs_reset)
        else $error("reset did not clear outputs");

    // Capture select falling loads the parallel inputs
    AST_CAPTURE: assert property (@(posedge clock) disable iff (rst)
        $fell(selects_n[code_input_capture]) |=> in_shift == $past(inputs_sync))
        else $error("inputs not captured");

    // Each SCK rise under the shift select moves the input register on
    AST_IN_SHIFT: assert property (@(posedge clock) disable iff (rst)
        sck_rise && !selects_n[code_input_shift] |=> in_shift == {$past(in_shift[n-2:0]), 1'b0})
        else $error("input register did not shift");

    // Without capture or shift the captured bits must stay put
    AST_IN_STILL: assert property (@(posedge clock) disable iff (rst)
        !capture_edge && !(sck_rise && !selects_n[code_input_shift]) |=> $stable(in_shift))
        else $error("input register moved while idle");

    // Main scenarios: a write, a full byte write, a capture, a read
    COV_OUT_WRITE: cover property (@(posedge clock) $rose(selects_n[code_output_expander]));
    COV_FULL_BYTE: cover property (@(posedge clock)
        $rose(selects_n[code_output_expander]) && out_bits == 4'(n));
    COV_CAPTURE: cover property (@(posedge clock) $fell(selects_n[code_input_capture]));
    COV_SHIFT_OUT: cover property (@(posedge clock) sck_rise && miso_oe);
endmodule : spi_port_expander

// ==== spi_master_model.sv ====
// Purpose: Behavioural SPI master with port select pins
// Assumes: Pins change 1 ns after a rising clock edge
// Notes: SCK idles low; each phase lasts 4 clocks
`timescale 1ns/1ns
module spi_master_model (
    input wire logic clock,
    input wire logic miso,
    output logic sck,
    output logic mosi,
    output logic [2:0] code
);
    // Idle pins at time zero
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        code = 3'h0;
    end

    // Code settles before any clocking for that target
    task automatic pick(input logic [2:0] c);
        @(posedge clock);
        #1 code = c;
        repeat (5) @(posedge clock);
        #1;
    endtask : pick

    // MSB first; MISO read before each rising SCK
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            rx[i] = miso;
            repeat (4) @(posedge clock);
            #1 sck = 1'b1;
            repeat (4) @(posedge clock);
            #1 sck = 1'b0;
        end
        mosi = ~mosi; // Idle data never holds the last bit
    endtask : xfer
endmodule : spi_master_model

// ==== tb.sv ====
// Purpose: Self-checking bench for the SPI port expander
// Assumes: Master model drives pins 1 ns after each rising edge
// Notes: Released MISO shows the inverse of its last level
`timescale 1ns/1ns
module tb;
    import spi_expander_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic sck, mosi, miso, miso_out, miso_oe;
    logic last_miso = 1'b0;
    logic [2:0] code;
    logic [7:0] inputs = 8'h3c;
    logic [7:0] selects_n, outs, rx;
    int err_count = 0;
    int samples_checked = 0;

    // Clock and wire resolution
    initial forever #25 clock = ~clock;
    always @(posedge clock) if (miso_oe) last_miso <= miso_out;
    assign miso = miso_oe ? miso_out : ~last_miso;

    spi_master_model spi_master_model_i (.clock(clock), .miso(miso), .sck(sck),
        .mosi(mosi), .code(code));
    spi_port_expander spi_port_expander_i (.clock(clock), .rst(rst), .sck(sck),
        .mosi(mosi), .select_code_pins(code), .expanded_inputs(inputs),
        .selects_n(selects_n), .expanded_outputs(outs), .miso_out(miso_out),
        .miso_oe(miso_oe));

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic summarize();
        $display("Checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    // Every code, one low select each
    task automatic t_decode();
        for (int c = 0; c < 8; c++) begin
            spi_master_model_i.pick(c[2:0]);
            chk("selects_n", ~(8'h01 << c), selects_n);
            chk("miso_oe", {7'h00, c == 4}, {7'h00, miso_oe});
        end
    endtask : t_decode

    // Write, latch on release, stray SCK, reset mid-run
    task automatic t_output();
        spi_master_model_i.pick(3'h5);
        spi_master_model_i.xfer(8'ha5, rx);
        chk("outputs_held", 8'h00, outs);
        spi_master_model_i.pick(3'h0);
        chk("outputs", 8'ha5, outs);
        spi_master_model_i.xfer(8'h0f, rx);
        spi_master_model_i.pick(3'h1);
        chk("outputs_idle", 8'ha5, outs);
        rst = 1'b1;
        @(posedge clock);
        #1 chk("outputs_rst", 8'h00, outs);
        rst = 1'b0;
    endtask : t_output

    // Capture, change every input bit, shift out, then capture the new pattern
    task automatic t_input();
        spi_master_model_i.pick(3'h3);
        inputs = 8'hc3;
        spi_master_model_i.pick(3'h4);
        spi_master_model_i.xfer(8'h00, rx);
        chk("miso_byte", 8'h3c, rx);
        spi_master_model_i.pick(3'h0);
        chk("miso_oe_off", 8'h00, {7'h00, miso_oe});
        spi_master_model_i.pick(3'h3);
        spi_master_model_i.pick(3'h4);
        spi_master_model_i.xfer(8'h00, rx);
        chk("miso_byte2", 8'hc3, rx);
    endtask : t_input

    initial begin
        repeat (3) @(posedge clock);
        #1 chk("selects_rst", 8'hff, selects_n);
        chk("outputs_rst", 8'h00, outs);
        rst = 1'b0;
        t_decode();
        t_output();
        t_input();
        summarize();
    end

    // Run needs about 360 clocks
    initial begin
        repeat (3000) @(posedge clock);
        err_count++;
        summarize();
    end
endmodule : tb
